// ==== design/iord_regs.vh ====
/*
  Constants of the I/O register space decoder: operation codes, address
  windows, register offsets (I/O numbering), bit masks and reset value.
  Assumes inclusion by iord_io_space.v only; definitions only.
*/
`ifndef IORD_REGS_VH
`define IORD_REGS_VH

// Operation codes on req_op
`define IORD_OP_IN 3'h0
`define IORD_OP_OUT 3'h1
`define IORD_OP_BIT_SET 3'h2
`define IORD_OP_BIT_CLEAR 3'h3
`define IORD_OP_SKIP_SET 3'h4
`define IORD_OP_SKIP_CLEAR 3'h5
`define IORD_OP_DS_READ 3'h6
`define IORD_OP_DS_WRITE 3'h7

// Address windows
`define IORD_SHORT_LAST 8'h3F
`define IORD_BIT_LAST 8'h1F
`define IORD_DS_OFFSET 8'h20
`define IORD_DS_IO_LAST 8'h5F
`define IORD_EXT_FIRST 8'h60
`define IORD_EXT_LAST 8'hFF

// Register offsets, I/O numbering
`define IORD_PORT_A_INPUT 6'h00
`define IORD_PORT_A_DIRECTION 6'h01
`define IORD_PORT_A_OUTPUT 6'h02
`define IORD_PORT_B_INPUT 6'h03
`define IORD_PORT_B_DIRECTION 6'h04
`define IORD_PORT_B_OUTPUT 6'h05
`define IORD_PORT_C_INPUT 6'h06
`define IORD_PORT_C_DIRECTION 6'h07
`define IORD_PORT_C_OUTPUT 6'h08
`define IORD_PORT_D_INPUT 6'h09
`define IORD_PORT_D_DIRECTION 6'h0A
`define IORD_PORT_D_OUTPUT 6'h0B
`define IORD_TIMER0_INT_FLAGS 6'h15
`define IORD_TIMER1_INT_FLAGS 6'h16
`define IORD_TIMER2_INT_FLAGS 6'h17
`define IORD_PIN_CHANGE_FLAGS 6'h1B
`define IORD_EXTERNAL_INT_FLAGS 6'h1C
`define IORD_EXTERNAL_INT_MASK 6'h1D
`define IORD_GENERAL_SCRATCH_0 6'h1E
`define IORD_EEPROM_CONTROL 6'h1F
`define IORD_EEPROM_DATA 6'h20
`define IORD_EEPROM_ADDR_LOW 6'h21
`define IORD_EEPROM_ADDR_HIGH 6'h22
`define IORD_TIMER_PRESCALER_CONTROL 6'h23
`define IORD_TIMER0_CONTROL_A 6'h24
`define IORD_TIMER0_CONTROL_B 6'h25
`define IORD_TIMER0_COUNT 6'h26
`define IORD_TIMER0_COMPARE_A 6'h27
`define IORD_TIMER0_COMPARE_B 6'h28
`define IORD_GENERAL_SCRATCH_1 6'h2A
`define IORD_GENERAL_SCRATCH_2 6'h2B
`define IORD_SERIAL_PERIPH_CONTROL 6'h2C
`define IORD_SERIAL_PERIPH_STATUS 6'h2D
`define IORD_SERIAL_PERIPH_DATA 6'h2E

// Implemented bits
`define IORD_MASK_FULL 8'hFF
`define IORD_MASK_NONE 8'h00
`define IORD_MASK_TIMER0_FLAGS 8'h07
`define IORD_MASK_TIMER1_FLAGS 8'h27
`define IORD_MASK_TIMER2_FLAGS 8'h07
`define IORD_MASK_PIN_CHANGE 8'h0F
`define IORD_MASK_EXT_FLAGS 8'h07
`define IORD_MASK_EXT_MASK 8'h07
`define IORD_MASK_EEPROM_CONTROL 8'h3F
`define IORD_MASK_EEPROM_ADDR_HIGH 8'h0F
`define IORD_MASK_PRESCALER 8'h83
`define IORD_MASK_TIMER0_CTRL_A 8'hF3
`define IORD_MASK_TIMER0_CTRL_B 8'h0F
`define IORD_MASK_SERIAL_STATUS_RW 8'h01
`define IORD_MASK_SERIAL_STATUS_RO 8'hC0
`define IORD_SERIAL_STATUS_RO_POS 6
`define IORD_RESET_VALUE 8'h00

`endif

// ==== design/iord_io_space.v ====
/*
  I/O register space decoder: short I/O forms, single-bit set/clear/test,
  data-space load/store with the +0x20 shift, extended region, W1C flags.
  Reserved I/O addresses read zero and drop writes, yet still pulse wr_pulse.
  Output ports are copies of flip-flops; the request decode is combinational.
  Assumes the core issues at most one request per clock, synchronous to clk;
  peripherals see writes through the registered write notification port.
*/
// Functional notes
// - Short I/O read/write reach only addresses 0x00 to 0x3F.
// - Data-space load/store sees I/O register N at address N plus 0x20.
// - Extended region 0x60 to 0xFF is reached by load/store only.
// - Single-bit set and clear work on addresses 0x00 to 0x1F only.
// - Skip-if-bit-set/clear tests read one bit within 0x00 to 0x1F.
// - Writing one clears a status flag; writing zero leaves it.
// - Bit set/clear writes back the whole register, clearing set flags except the target bit of a bit clear.
`include "iord_regs.vh"

module iord_io_space (
  input wire clk,
  input wire reset,
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [7:0] req_addr,
  input wire [2:0] req_bit,
  input wire [7:0] req_wdata,
  input wire [7:0] port_a_pins,
  input wire [7:0] port_b_pins,
  input wire [7:0] port_c_pins,
  input wire [7:0] port_d_pins,
  input wire [7:0] timer0_flag_set,
  input wire [7:0] timer1_flag_set,
  input wire [7:0] timer2_flag_set,
  input wire [7:0] pin_change_flag_set,
  input wire [7:0] external_flag_set,
  input wire [1:0] serial_status_in,
  output wire ans_valid,
  output wire [7:0] ans_rdata,
  output wire ans_skip,
  output wire req_refused,
  output wire wr_pulse,
  output wire [5:0] wr_index,
  output wire [7:0] wr_data,
  output wire [7:0] port_a_direction,
  output wire [7:0] port_a_output,
  output wire [7:0] port_b_direction,
  output wire [7:0] port_b_output,
  output wire [7:0] port_c_direction,
  output wire [7:0] port_c_output,
  output wire [7:0] port_d_direction,
  output wire [7:0] port_d_output
);

  // Bits that software may write and read back as stored
  function [7:0] rw_mask;
    input [5:0] a;
    begin
      case (a)
        `IORD_PORT_A_DIRECTION, `IORD_PORT_A_OUTPUT,
        `IORD_PORT_B_DIRECTION, `IORD_PORT_B_OUTPUT,
        `IORD_PORT_C_DIRECTION, `IORD_PORT_C_OUTPUT,
        `IORD_PORT_D_DIRECTION, `IORD_PORT_D_OUTPUT,
        `IORD_GENERAL_SCRATCH_0, `IORD_EEPROM_DATA,
        `IORD_EEPROM_ADDR_LOW, `IORD_TIMER0_COUNT,
        `IORD_TIMER0_COMPARE_A, `IORD_TIMER0_COMPARE_B,
        `IORD_GENERAL_SCRATCH_1, `IORD_GENERAL_SCRATCH_2,
        `IORD_SERIAL_PERIPH_CONTROL, `IORD_SERIAL_PERIPH_DATA:
          rw_mask = `IORD_MASK_FULL;
        `IORD_EXTERNAL_INT_MASK:
          rw_mask = `IORD_MASK_EXT_MASK;
        `IORD_EEPROM_CONTROL:
          rw_mask = `IORD_MASK_EEPROM_CONTROL;
        `IORD_EEPROM_ADDR_HIGH:
          rw_mask = `IORD_MASK_EEPROM_ADDR_HIGH;
        `IORD_TIMER_PRESCALER_CONTROL:
          rw_mask = `IORD_MASK_PRESCALER;
        `IORD_TIMER0_CONTROL_A:
          rw_mask = `IORD_MASK_TIMER0_CTRL_A;
        `IORD_TIMER0_CONTROL_B:
          rw_mask = `IORD_MASK_TIMER0_CTRL_B;
        `IORD_SERIAL_PERIPH_STATUS:
          rw_mask = `IORD_MASK_SERIAL_STATUS_RW;
        default:
          rw_mask = `IORD_MASK_NONE;
      endcase
    end
  endfunction

  // Flag bits that hardware sets and a written one clears
  function [7:0] w1c_mask;
    input [5:0] a;
    begin
      case (a)
        `IORD_TIMER0_INT_FLAGS: w1c_mask = `IORD_MASK_TIMER0_FLAGS;
        `IORD_TIMER1_INT_FLAGS: w1c_mask = `IORD_MASK_TIMER1_FLAGS;
        `IORD_TIMER2_INT_FLAGS: w1c_mask = `IORD_MASK_TIMER2_FLAGS;
        `IORD_PIN_CHANGE_FLAGS: w1c_mask = `IORD_MASK_PIN_CHANGE;
        `IORD_EXTERNAL_INT_FLAGS: w1c_mask = `IORD_MASK_EXT_FLAGS;
        default: w1c_mask = `IORD_MASK_NONE;
      endcase
    end
  endfunction

  // Next byte of one register: stored bits take the write, written ones
  // clear flags, and a hardware set in the same cycle beats that clear
  function [7:0] merge_byte;
    input [7:0] old_value;
    input [7:0] new_value;
    input write_en;
    input [7:0] keep_mask;
    input [7:0] flag_mask;
    input [7:0] set_value;
    reg [7:0] merged;
    begin
      merged = old_value;
      if (write_en)
      begin
        merged = (old_value & ~keep_mask) | (new_value & keep_mask);
        merged = merged & ~(new_value & flag_mask);
      end
      merge_byte = merged | (set_value & flag_mask);
    end
  endfunction

  // An I/O register sits at its I/O address plus 0x20 in data space
  function [5:0] ds_to_io;
    input [7:0] ds_addr;
    reg [7:0] shifted;
    begin
      shifted = ds_addr - `IORD_DS_OFFSET;
      ds_to_io = shifted[5:0];
    end
  endfunction

  // Only the implemented addresses hold flip-flops that matter; the rest
  // are masked to zero and trimmed by synthesis.
  reg [7:0] mem_reg [0:63];
  reg [7:0] mem_next [0:63];

  reg is_short;
  reg is_bit_rmw;
  reg is_test;
  reg is_write;
  reg is_read;
  reg legal;
  reg io_hit;
  reg [5:0] idx;
  reg [7:0] rd_value;
  reg [7:0] wr_value;
  reg [7:0] bit_sel;
  reg [7:0] set_vec;
  reg do_write;
  integer i;
  integer j;

  // Registered answer state behind the output ports
  reg answer_hit;
  reg test_hit;
  reg ans_valid_reg;
  reg ans_valid_next;
  reg [7:0] ans_rdata_reg;
  reg [7:0] ans_rdata_next;
  reg ans_skip_reg;
  reg ans_skip_next;
  reg req_refused_reg;
  reg req_refused_next;
  reg wr_pulse_reg;
  reg wr_pulse_next;
  reg [5:0] wr_index_reg;
  reg [5:0] wr_index_next;
  reg [7:0] wr_data_reg;
  reg [7:0] wr_data_next;

  // Request decode
  always @*
  begin
    is_short = (req_op != `IORD_OP_DS_READ) && (req_op != `IORD_OP_DS_WRITE);
    is_bit_rmw = (req_op == `IORD_OP_BIT_SET) || (req_op == `IORD_OP_BIT_CLEAR);
    is_test = (req_op == `IORD_OP_SKIP_SET) || (req_op == `IORD_OP_SKIP_CLEAR);
    is_write = (req_op == `IORD_OP_OUT) || (req_op == `IORD_OP_DS_WRITE) || is_bit_rmw;
    is_read = (req_op == `IORD_OP_IN) || (req_op == `IORD_OP_DS_READ);
    idx = req_addr[5:0];
    io_hit = 1'b0;
    legal = 1'b0;
    if (is_bit_rmw || is_test)
    begin
      legal = (req_addr <= `IORD_BIT_LAST);
      io_hit = legal;
    end
    else if (is_short)
    begin
      legal = (req_addr <= `IORD_SHORT_LAST);
      io_hit = legal;
    end
    else if (req_addr >= `IORD_EXT_FIRST)
    begin
      // Extended region: no register of this block lives there
      legal = 1'b1;
      io_hit = 1'b0;
    end
    else if (req_addr >= `IORD_DS_OFFSET)
    begin
      legal = 1'b1;
      io_hit = 1'b1;
      idx = ds_to_io(req_addr);
    end
    else
    begin
      // Below 0x20 the data space is the core's register file
      legal = 1'b0;
      io_hit = 1'b0;
    end
  end

  // Read value of the addressed register; unimplemented bits read zero
  always @*
  begin
    rd_value = mem_reg[idx] & (rw_mask(idx) | w1c_mask(idx));
    case (idx)
      `IORD_PORT_A_INPUT: rd_value = port_a_pins;
      `IORD_PORT_B_INPUT: rd_value = port_b_pins;
      `IORD_PORT_C_INPUT: rd_value = port_c_pins;
      `IORD_PORT_D_INPUT: rd_value = port_d_pins;
      `IORD_SERIAL_PERIPH_STATUS:
        rd_value = rd_value |
          ({serial_status_in, 6'h00} & `IORD_MASK_SERIAL_STATUS_RO);
      default: rd_value = rd_value;
    endcase
    if (!io_hit)
      rd_value = 8'h00;
  end

  // Value written back; bit ops rewrite the whole byte as read
  always @*
  begin
    bit_sel = 8'h01 << req_bit;
    case (req_op)
      `IORD_OP_BIT_SET: wr_value = rd_value | bit_sel;
      `IORD_OP_BIT_CLEAR: wr_value = rd_value & ~bit_sel;
      default: wr_value = req_wdata;
    endcase
    do_write = req_valid && legal && io_hit && is_write;
  end

  // Register update: flag sets win over a clear in the same cycle
  always @*
  begin
    for (i = 0; i < 64; i = i + 1)
    begin
      case (i[5:0])
        `IORD_TIMER0_INT_FLAGS: set_vec = timer0_flag_set;
        `IORD_TIMER1_INT_FLAGS: set_vec = timer1_flag_set;
        `IORD_TIMER2_INT_FLAGS: set_vec = timer2_flag_set;
        `IORD_PIN_CHANGE_FLAGS: set_vec = pin_change_flag_set;
        `IORD_EXTERNAL_INT_FLAGS: set_vec = external_flag_set;
        default: set_vec = 8'h00;
      endcase
      mem_next[i] = merge_byte(mem_reg[i], wr_value, do_write && (idx == i[5:0]),
        rw_mask(i[5:0]), w1c_mask(i[5:0]), set_vec);
    end
  end

  always @(posedge clk)
  begin
    for (j = 0; j < 64; j = j + 1)
    begin
      if (reset)
        mem_reg[j] <= `IORD_RESET_VALUE;
      else
        mem_reg[j] <= mem_next[j];
    end
  end

  // Answer values; read data and write notes hold until replaced
  always @*
  begin
    answer_hit = req_valid && legal && (is_read || is_test);
    test_hit = req_valid && legal && is_test;
    ans_valid_next = answer_hit;
    req_refused_next = req_valid && !legal;
    ans_rdata_next = ans_rdata_reg;
    if (answer_hit)
      ans_rdata_next = rd_value;
    ans_skip_next = 1'b0;
    if (test_hit && (req_op == `IORD_OP_SKIP_SET))
      ans_skip_next = rd_value[req_bit];
    else if (test_hit)
      ans_skip_next = !rd_value[req_bit];
    wr_pulse_next = do_write;
    wr_index_next = wr_index_reg;
    wr_data_next = wr_data_reg;
    if (do_write)
    begin
      wr_index_next = idx;
      wr_data_next = wr_value;
    end
  end

  // Answers stand in the cycle after the request edge
  always @(posedge clk)
  begin
    if (reset)
    begin
      ans_valid_reg <= 1'b0;
      ans_rdata_reg <= 8'h00;
      ans_skip_reg <= 1'b0;
      req_refused_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_index_reg <= 6'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      ans_valid_reg <= ans_valid_next;
      ans_rdata_reg <= ans_rdata_next;
      ans_skip_reg <= ans_skip_next;
      req_refused_reg <= req_refused_next;
      wr_pulse_reg <= wr_pulse_next;
      wr_index_reg <= wr_index_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // Outputs are plain copies of flip-flops, so no decode glitch reaches a port
  assign ans_valid = ans_valid_reg;
  assign ans_rdata = ans_rdata_reg;
  assign ans_skip = ans_skip_reg;
  assign req_refused = req_refused_reg;
  assign wr_pulse = wr_pulse_reg;
  assign wr_index = wr_index_reg;
  assign wr_data = wr_data_reg;

  assign port_a_direction = mem_reg[`IORD_PORT_A_DIRECTION];
  assign port_a_output = mem_reg[`IORD_PORT_A_OUTPUT];
  assign port_b_direction = mem_reg[`IORD_PORT_B_DIRECTION];
  assign port_b_output = mem_reg[`IORD_PORT_B_OUTPUT];
  assign port_c_direction = mem_reg[`IORD_PORT_C_DIRECTION];
  assign port_c_output = mem_reg[`IORD_PORT_C_OUTPUT];
  assign port_d_direction = mem_reg[`IORD_PORT_D_DIRECTION];
  assign port_d_output = mem_reg[`IORD_PORT_D_OUTPUT];

endmodule

// ==== testbench/iord_io_space_asserts.sv ====
/* Assertions on the core request port of the I/O space decoder.
   Assumes a bind into iord_io_space; one clock, synchronous reset. */
module iord_chk (
  input wire clk,
  input wire reset,
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [7:0] req_addr,
  input wire [2:0] req_bit,
  input wire [7:0] req_wdata,
  input wire ans_valid,
  input wire [7:0] ans_rdata,
  input wire ans_skip,
  input wire req_refused,
  input wire wr_pulse,
  input wire [5:0] wr_index,
  input wire [7:0] port_a_output
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_short;
    req_valid && req_op < 3'h2 && req_addr > 8'h3F |=> req_refused && !wr_pulse;
  endproperty
  a_short: assert property (p_short) else $error("short op accepted");
  property p_port;
    req_valid && req_op == 3'h1 && req_addr == 8'h02 |=> port_a_output == $past(req_wdata);
  endproperty
  a_port: assert property (p_port) else $error("port write lost");
  property p_shift;
    req_valid && req_op == 3'h7 && req_addr inside {[8'h20:8'h5F]}
      |=> wr_pulse && {2'h0, wr_index} == $past(req_addr) - 8'h20;
  endproperty
  a_shift: assert property (p_shift) else $error("store index wrong");
  property p_low;
    req_valid && req_op[2:1] == 2'h3 && req_addr < 8'h20 |=> req_refused && !ans_valid;
  endproperty
  a_low: assert property (p_low) else $error("low load accepted");
  property p_ext;
    req_valid && req_op == 3'h6 && req_addr > 8'h5F |=> ans_valid && ans_rdata == 8'h00;
  endproperty
  a_ext: assert property (p_ext) else $error("extended load wrong");
  property p_bit;
    req_valid && req_op[2:1] == 2'h1 && req_addr > 8'h1F |=> req_refused && !wr_pulse;
  endproperty
  a_bit: assert property (p_bit) else $error("bit op accepted");
  property p_set;
    req_valid && req_op == 3'h4 && req_addr < 8'h20 |=> ans_skip == ans_rdata[$past(req_bit)];
  endproperty
  a_set: assert property (p_set) else $error("set test wrong");
  property p_clr;
    req_valid && req_op == 3'h5 && req_addr < 8'h20 |=> ans_skip != ans_rdata[$past(req_bit)];
  endproperty
  a_clr: assert property (p_clr) else $error("clear test wrong");
endmodule

bind iord_io_space iord_chk iord_chk_i (.clk, .reset, .req_valid, .req_op, .req_addr,
  .req_bit, .req_wdata, .ans_valid, .ans_rdata, .ans_skip, .req_refused, .wr_pulse,
  .wr_index, .port_a_output);

// ==== testbench/iord_core_model.sv ====
/* Behavioural processor core issuing one request at a time.
   Assumes answers stand in the cycle after the taking edge. */
module iord_core_model (
  input wire clk,
  output logic req_valid,
  output logic [2:0] req_op,
  output logic [7:0] req_addr,
  output logic [2:0] req_bit,
  output logic [7:0] req_wdata,
  input wire [7:0] ans_rdata,
  input wire ans_skip,
  input wire req_refused
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    req_valid = 1'b0;
    req_op = 3'h0;
    req_addr = 8'h00;
    req_bit = 3'h0;
    req_wdata = 8'h00;
  end
  // Write targets and data pass through as the caller chose them
  task automatic issue(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] wd, output logic [7:0] rd, output logic sk, output logic rf);
    @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_bit = b;
    req_wdata = wd;
    @(negedge clk);
    // Skip and refusal answers stand one cycle only, so they are taken mid-cycle
    rd = ans_rdata;
    sk = ans_skip;
    rf = req_refused;
    req_valid = 1'b0;
  endtask
endmodule

// ==== testbench/testbench.sv ====
/* Self-checking bench of the I/O space decoder.
   Assumes the design header on the include path. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] pins [4];
  logic [7:0] fset = 8'h00;
  logic [31:0] rng = 32'h6E93;
  logic [7:0] rd, v, d, a;
  logic sk, rf;
  integer err_count = 0;
  integer check_count = 0;
  wire req_valid, ans_valid, ans_skip, req_refused, wr_pulse;
  wire [2:0] req_op, req_bit;
  wire [7:0] req_addr, req_wdata, ans_rdata, wr_dat;
  wire [5:0] wr_idx;
  wire [7:0] po [8];
  logic [7:0] rw_tab [16] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
    8'h1D, 8'h1E, 8'h21, 8'h22, 8'h23, 8'h24, 8'h2A, 8'h2E};
  logic [7:0] fl_a [5] = '{8'h15, 8'h16, 8'h17, 8'h1B, 8'h1C};
  logic [7:0] fl_m [5] = '{8'h07, 8'h27, 8'h07, 8'h0F, 8'h07};
  logic [2:0] c_op [13] = '{3'h0, 3'h0, 3'h0, 3'h6, 3'h6, 3'h0, 3'h1, 3'h3, 3'h2, 3'h4,
    3'h5, 3'h6, 3'h7};
  logic [7:0] c_a [13] = '{8'h0C, 8'h2F, 8'h30, 8'h80, 8'hFF, 8'h40, 8'h42, 8'h22, 8'h3F,
    8'h20, 8'hFF, 8'h1F, 8'h02};
  always #10 clk = ~clk;
  iord_io_space iord_io_space_i (.clk, .reset, .req_valid, .req_op, .req_addr, .req_bit,
    .req_wdata, .port_a_pins(pins[0]), .port_b_pins(pins[1]), .port_c_pins(pins[2]),
    .port_d_pins(pins[3]), .timer0_flag_set(fset), .timer1_flag_set(fset),
    .timer2_flag_set(fset), .pin_change_flag_set(fset), .external_flag_set(fset),
    .serial_status_in(2'h0), .ans_valid, .ans_rdata, .ans_skip, .req_refused, .wr_pulse,
    .wr_index(wr_idx), .wr_data(wr_dat), .port_a_direction(po[0]), .port_a_output(po[1]),
    .port_b_direction(po[2]), .port_b_output(po[3]), .port_c_direction(po[4]),
    .port_c_output(po[5]), .port_d_direction(po[6]), .port_d_output(po[7]));
  iord_core_model core_i (.clk, .req_valid, .req_op, .req_addr, .req_bit, .req_wdata,
    .ans_rdata, .ans_skip, .req_refused);
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  function automatic logic [7:0] rw_mask(input logic [7:0] x);
    case (x)
      8'h1D: return 8'h07;
      8'h22: return 8'h0F;
      8'h23: return 8'h83;
      8'h24: return 8'hF3;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic go(input logic [2:0] op, input logic [7:0] x, input logic [2:0] b,
    input logic [7:0] wd);
    core_i.issue(op, x, b, wd, rd, sk, rf);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    foreach (pins[i]) pins[i] = rnd();
    repeat (10) @(negedge clk);
    reset = 1'b0;
    chk(po[1], 8'h00);
    repeat (40)
    begin
      v = rnd();
      a = rw_tab[v[3:0]];
      d = rnd();
      go(v[4] ? 3'h1 : 3'h7, v[4] ? a : a + 8'h20, 3'h0, d);
      chk(wr_dat, d);
      chk({2'h0, wr_idx}, a);
      go(v[5] ? 3'h0 : 3'h6, v[5] ? a : a + 8'h20, 3'h0, 8'h00);
      chk(rd, d & rw_mask(a));
      if (a <= 8'h0B)
        chk(po[a - a / 8'h03 - 8'h01], d);
    end
    for (int i = 0; i < 4; i++)
    begin
      go(3'h6, 8'(i * 3 + 32), 3'h0, 8'h00);
      chk(rd, pins[i]);
    end
    go(3'h1, 8'h02, 3'h0, 8'h5A);
    // Reserved and extended reads answer zero; the other ops are refused, all but 0x3F and 0xFF aliasing live registers if truncated
    foreach (c_op[i])
    begin
      go(c_op[i], c_a[i], 3'h1, 8'hFF);
      chk((i > 4) ? {7'h00, rf} : rd | {7'h00, rf}, 8'(i > 4));
    end
    go(3'h0, 8'h02, 3'h0, 8'h00);
    chk(rd, 8'h5A);
    v = 8'h5A;
    for (int b = 0; b < 8; b++)
    begin
      d = rnd();
      go(d[0] ? 3'h2 : 3'h3, 8'h02, 3'(b), 8'h00);
      v[b] = d[0];
      go(d[1] ? 3'h4 : 3'h5, 8'h02, 3'(b), 8'h00);
      chk({7'h00, sk}, {7'h00, d[1] ? v[b] : !v[b]});
    end
    chk(po[1], v);
    fset = 8'hFF;
    @(negedge clk);
    fset = 8'h00;
    foreach (fl_a[i])
    begin
      go(3'h6, fl_a[i] + 8'h20, 3'h0, 8'h00);
      chk(rd, fl_m[i]);
      go(3'h1, fl_a[i], 3'h0, 8'h01);
      go(3'h1, fl_a[i], 3'h0, 8'h00);
      go(3'h0, fl_a[i], 3'h0, 8'h00);
      chk(rd, fl_m[i] & 8'hFE);
      go(i[0] ? 3'h3 : 3'h2, fl_a[i], 3'(i), 8'h00);
      go(3'h0, fl_a[i], 3'h0, 8'h00);
      chk(rd, i[0] ? fl_m[i] & 8'hFE & (8'h01 << i) : 8'h00);
    end
    wrap_up();
  end
endmodule
